/* armc_map.svh */
// Offsets, field values and counts for the read multiple block
`ifndef ARMC_MAP_SVH
`define ARMC_MAP_SVH
`define ARMC_A_DATA     6'h00
`define ARMC_A_FEAT     6'h04
`define ARMC_A_SCNT     6'h08
`define ARMC_A_SNUM     6'h0c
`define ARMC_A_CLO      6'h10
`define ARMC_A_CHI      6'h14
`define ARMC_A_DEVH     6'h18
`define ARMC_A_CMD      6'h1c
`define ARMC_A_ERR      6'h20
`define ARMC_A_CTRL     6'h24
`define ARMC_A_BLK      6'h28
`define ARMC_CMD_RM28   8'hc4
`define ARMC_CMD_RM48   8'h29
`define ARMC_ST_FIXED   8'h50
`define ARMC_ST_BSY     8'h80
`define ARMC_ST_DRQ     8'h08
`define ARMC_ST_ERR     8'h01
`define ARMC_ER_UNC     8'h40
`define ARMC_ER_IDN     8'h10
`define ARMC_ER_ABT     8'h04
`define ARMC_HOB_BIT    7
`define ARMC_DH_RST     8'ha0
`define ARMC_SECT_LAST  8'hff
`define ARMC_CNT28_ZERO 17'h00100
`define ARMC_CNT48_ZERO 17'h10000
`define ARMC_FIFO_W     16
`define ARMC_FIFO_D     32
`endif

/* armc_media_model.sv */
// Media side model that streams sector words on request
`timescale 1ns/1ns
module armc_media_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        media_req,
  input  wire logic [47:0] media_lba,
  input  wire logic        media_ready,
  output logic             media_valid,
  output logic [15:0]      media_data,
  output logic             media_err,
  output logic             media_err_idn,
  input  wire logic        err_arm,
  input  wire logic [47:0] err_lba,
  input  wire logic        err_idn_sel
);
  logic [47:0] base_r;
  logic [8:0]  cnt_r;
  logic [1:0]  tick_r;
  logic        act_r;
  logic [8:0]  nxt;

  assign nxt = cnt_r + 9'(media_valid && media_ready);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_r <= '0;
      cnt_r <= '0;
      tick_r <= '0;
      act_r <= 1'b0;
      media_valid <= 1'b0;
      media_data <= 16'h5a5a;
      media_err <= 1'b0;
      media_err_idn <= 1'b0;
    end else begin
      tick_r <= tick_r + 2'h1;
      media_err <= 1'b0;
      if (!act_r) begin
        media_data <= ~media_data;
      end
      if (media_req) begin
        base_r <= media_lba;
        cnt_r <= '0;
        act_r <= 1'b1;
        media_valid <= 1'b0;
      end else if (act_r && err_arm && base_r == err_lba) begin
        media_err <= 1'b1;
        media_err_idn <= err_idn_sel;
        act_r <= 1'b0;
        media_valid <= 1'b0;
      end else if (act_r) begin
        cnt_r <= nxt;
        if (nxt == 9'h100) begin
          act_r <= 1'b0;
          media_valid <= 1'b0;
        end else if (!media_valid || media_ready) begin
          media_valid <= tick_r != 2'h0;
          media_data <= {base_r[7:0], nxt[7:0]};
        end
      end
    end
  end
endmodule

/* armc_pkg.sv */
// Types for the read multiple block
package armc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEEK,
    ST_STREAM,
    ST_DRAIN
  } armc_state_t;
endpackage

/* armc_tb.sv */
// Testbench for the read multiple command engine
`timescale 1ns/1ns
`include "armc_map.svh"
module testbench;
  logic        ref_clk;
  logic        nrst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        host_intrq;
  logic        media_req;
  logic [47:0] media_lba;
  logic        media_valid;
  logic [15:0] media_data;
  logic        media_ready;
  logic        media_err;
  logic        media_err_idn;
  logic        err_arm;
  logic [47:0] err_lba;
  logic        err_idn_sel;
  logic [31:0] q;
  int          n_fail;
  int          samples_checked;
  int          cyc;
  localparam logic [47:0] BASE = 48'ha1b2c3d4e5f6;

  armc_top i_dut (.ref_clk(ref_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .host_intrq(host_intrq), .media_req(media_req), .media_lba(media_lba),
    .media_valid(media_valid), .media_data(media_data),
    .media_ready(media_ready), .media_err(media_err),
    .media_err_idn(media_err_idn));

  armc_media_model i_media (.clk(ref_clk), .rst_n(nrst),
    .media_req(media_req), .media_lba(media_lba), .media_ready(media_ready),
    .media_valid(media_valid), .media_data(media_data),
    .media_err(media_err), .media_err_idn(media_err_idn),
    .err_arm(err_arm), .err_lba(err_lba), .err_idn_sel(err_idn_sel));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Checks and bus tasks
  // ****************************************
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    input logic [3:0] be = 4'h1);
    bus(1'b1, a, {24'h0, d}, be);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp,
                    input logic [31:0] m = 32'hffffffff);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(q & m, exp);
  endtask

  task automatic rd_words(input int n, input logic [47:0] l);
    logic [47:0] s;
    for (int k = 0; k < n; k++) begin
      bus(1'b0, `ARMC_A_DATA, 32'h0, 4'hf);
      s = l + 48'(k / 256);
      chk(q, {16'h0, s[7:0], 8'(k)});
    end
  endtask

  task automatic tf48(input logic [15:0] c, input logic [47:0] l);
    wr(`ARMC_A_SCNT, c[15:8]);
    wr(`ARMC_A_SCNT, c[7:0]);
    wr(`ARMC_A_SNUM, l[31:24]);
    wr(`ARMC_A_SNUM, l[7:0]);
    wr(`ARMC_A_CLO, l[39:32]);
    wr(`ARMC_A_CLO, l[15:8]);
    wr(`ARMC_A_CHI, l[47:40]);
    wr(`ARMC_A_CHI, l[23:16]);
    wr(`ARMC_A_DEVH, 8'h40);
    wr(`ARMC_A_CMD, `ARMC_CMD_RM48);
    repeat (2) @(posedge ref_clk);
    chk(host_intrq, 1);
    rd(`ARMC_A_CMD, 32'h58);
  endtask

  task automatic hob(input logic [47:0] l);
    rd(`ARMC_A_SNUM, l[7:0]);
    rd(`ARMC_A_CLO, l[15:8]);
    rd(`ARMC_A_CHI, l[23:16]);
    wr(`ARMC_A_CTRL, 8'h80);
    rd(`ARMC_A_SNUM, l[31:24]);
    rd(`ARMC_A_CLO, l[39:32]);
    rd(`ARMC_A_CHI, l[47:40]);
    wr(`ARMC_A_CTRL, 8'h00);
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h1;
    avs_writedata = '0;
    err_arm = 1'b0;
    err_lba = '0;
    err_idn_sel = 1'b0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(`ARMC_A_CMD, 32'h50);
    rd(`ARMC_A_ERR, 32'h0);
    rd(`ARMC_A_DEVH, 32'ha0);
    rd(`ARMC_A_BLK, 32'h0);
    rd(6'h2c, 32'h0);
    wr(`ARMC_A_CMD, `ARMC_CMD_RM28);
    repeat (2) @(posedge ref_clk);
    chk(host_intrq, 1);
    rd(`ARMC_A_ERR, 32'h04);
    rd(`ARMC_A_CMD, 32'h51);
    // Status read clears the line at the answer edge; look one edge later
    @(posedge ref_clk);
    chk(host_intrq, 0);
    wr(`ARMC_A_BLK, 8'h02);
    wr(`ARMC_A_BLK, 8'h05, 4'h0);
    rd(`ARMC_A_BLK, 32'h02);
    wr(`ARMC_A_CMD, 8'h20);
    rd(`ARMC_A_ERR, 32'h04);
    // 28-bit read of three sectors in blocks of two
    wr(`ARMC_A_SCNT, 8'h03);
    wr(`ARMC_A_SNUM, 8'h56);
    wr(`ARMC_A_CLO, 8'h34);
    wr(`ARMC_A_CHI, 8'h12);
    wr(`ARMC_A_DEVH, 8'he5);
    wr(`ARMC_A_CMD, `ARMC_CMD_RM28);
    repeat (2) @(posedge ref_clk);
    chk(host_intrq, 1);
    rd(`ARMC_A_CMD, 32'h58);
    @(posedge ref_clk);
    chk(host_intrq, 0);
    repeat (100) @(posedge ref_clk);
    chk(media_ready, 0);
    rd_words(512, 48'h5123456);
    repeat (2) @(posedge ref_clk);
    chk(host_intrq, 1);
    rd(`ARMC_A_CMD, 32'h58);
    rd_words(256, 48'h5123458);
    repeat (2) @(posedge ref_clk);
    chk(host_intrq, 0);
    rd(`ARMC_A_CMD, 32'h50);
    rd(`ARMC_A_SNUM, 32'h58);
    rd(`ARMC_A_CLO, 32'h34);
    rd(`ARMC_A_CHI, 32'h12);
    rd(`ARMC_A_DEVH, 32'h5, 32'hf);
    rd(`ARMC_A_SCNT, 32'h0);
    chk(media_ready, 1);
    // 48-bit read of one sector
    tf48(16'h0001, BASE);
    rd_words(256, BASE);
    rd(`ARMC_A_CMD, 32'h50);
    hob(BASE);
    // Media failure on the second sector, both error kinds
    // Second pass uses a zero count, which stands for 65536 sectors
    for (int e = 0; e < 2; e++) begin
      tf48((e == 1) ? 16'h0000 : 16'h0002, BASE);
      rd_words(256, BASE);
      err_lba <= BASE + 48'h1;
      err_idn_sel <= 1'(e);
      err_arm <= 1'b1;
      repeat (60) @(posedge ref_clk);
      err_arm <= 1'b0;
      chk(host_intrq, 1);
      rd(`ARMC_A_ERR, (e == 1) ? 32'h10 : 32'h40);
      rd(`ARMC_A_CMD, 32'h51);
      hob(BASE + 48'h1);
      rd(`ARMC_A_DATA, 32'h0);
    end
    wrap_up();
  end
endmodule

/* armc_top.sv */
// Read multiple command engine with its sector data FIFO
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "armc_map.svh"

// ****************************************
// Sector data FIFO
// ****************************************
module armc_fifo #(
  parameter int W = `ARMC_FIFO_W,
  parameter int D = `ARMC_FIFO_D
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          in_ready_r;
  logic          out_valid_r;
  logic          push;
  logic          pop;

  assign push = in_valid && in_ready_r && !flush;
  assign pop = out_ready && out_valid_r && !flush;
  assign in_ready = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = mem_r[rd_r];

  always_comb begin
    if (flush) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r        <= '0;
      rd_r        <= '0;
      cnt_r       <= '0;
      in_ready_r  <= 1'b0;
      out_valid_r <= 1'b0;
    end else begin
      if (flush) begin
        wr_r <= '0;
        rd_r <= '0;
      end else begin
        if (push) begin
          wr_r <= wr_r + 1'b1;
        end
        if (pop) begin
          rd_r <= rd_r + 1'b1;
        end
      end
      cnt_r       <= cnt_nxt;
      in_ready_r  <= cnt_nxt != (AW+1)'(D);
      out_valid_r <= cnt_nxt != '0;
    end
  end
endmodule

module armc_top (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             host_intrq,
  output logic             media_req,
  output logic [47:0]      media_lba,
  input  wire logic        media_valid,
  input  wire logic [15:0] media_data,
  output logic             media_ready,
  input  wire logic        media_err,
  input  wire logic        media_err_idn
);
  armc_pkg::armc_state_t state_r;
  logic        wait_r;
  logic        intrq_r;
  logic        drq_r;
  logic        req_r;
  logic        cmd48_r;
  logic        hob_r;
  logic        sterr_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  logic [47:0] lba_r;
  logic [47:0] mlba_r;
  logic [47:0] start_lba;
  logic [47:0] last_lba;
  logic [47:0] wb_lba;
  logic [16:0] sect_left_r;
  logic [16:0] start_cnt;
  logic [15:0] pop_left_r;
  logic [15:0] fifo_data;
  logic [7:0]  blk_r;
  logic [7:0]  blk_sect_r;
  logic [7:0]  push_cnt_r;
  logic [7:0]  err_r;
  logic [7:0]  cmd;
  logic [7:0]  sc_r;
  logic [7:0]  sc_p_r;
  logic [7:0]  sn_r;
  logic [7:0]  sn_p_r;
  logic [7:0]  cl_r;
  logic [7:0]  cl_p_r;
  logic [7:0]  ch_r;
  logic [7:0]  ch_p_r;
  logic [7:0]  dh_r;
  logic        acc;
  logic        busy;
  logic        push;
  logic        pop;
  logic        fail;
  logic        blk_end;
  logic        done;
  logic        tf_wr;
  logic        cmd_wr;
  logic        go;
  logic        abort;
  logic        rd_ok;
  logic        fifo_valid;
  logic        fifo_ready;

  function automatic logic [7:0] pick(input logic h,
                                      input logic [7:0] c,
                                      input logic [7:0] p);
    return h ? p : c;
  endfunction

  function automatic logic [7:0] take_of(input logic [16:0] n,
                                         input logic [7:0] b);
    return (n < {9'h000, b}) ? n[7:0] : b;
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  assign acc = !wait_r && (avs_read || avs_write);
  assign busy = state_r != armc_pkg::ST_IDLE;
  assign push = media_valid && fifo_ready;
  assign pop = acc && avs_read && avs_address == `ARMC_A_DATA && drq_r;
  assign fail = media_err && busy;
  assign blk_end = pop && pop_left_r == 16'h0001;
  assign done = blk_end && sect_left_r == 17'h00000;
  assign cmd = avs_writedata[7:0];
  assign tf_wr = acc && avs_write && avs_byteenable[0] && !busy;
  assign cmd_wr = tf_wr && avs_address == `ARMC_A_CMD;
  assign go = cmd_wr && blk_r != 8'h00 &&
              (cmd == `ARMC_CMD_RM28 || cmd == `ARMC_CMD_RM48);
  assign abort = cmd_wr && !go;
  assign rd_ok = !(avs_read && avs_address == `ARMC_A_DATA &&
                   drq_r && !fifo_valid);
  assign last_lba = lba_r - 48'h000000000001;
  assign wb_lba = fail ? lba_r : last_lba;

  always_comb begin
    if (cmd == `ARMC_CMD_RM48) begin
      start_lba = {ch_p_r, cl_p_r, sn_p_r, ch_r, cl_r, sn_r};
      start_cnt = {1'b0, sc_p_r, sc_r};
      if ({sc_p_r, sc_r} == 16'h0000) begin
        start_cnt = `ARMC_CNT48_ZERO;
      end
    end else begin
      start_lba = {20'h00000, dh_r[3:0], ch_r, cl_r, sn_r};
      start_cnt = {9'h000, sc_r};
      if (sc_r == 8'h00) begin
        start_cnt = `ARMC_CNT28_ZERO;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (avs_address)
      `ARMC_A_DATA: rd_mux[15:0] = drq_r ? fifo_data : 16'h0000;
      `ARMC_A_SCNT: rd_mux[7:0] = pick(hob_r, sc_r, sc_p_r);
      `ARMC_A_SNUM: rd_mux[7:0] = pick(hob_r, sn_r, sn_p_r);
      `ARMC_A_CLO:  rd_mux[7:0] = pick(hob_r, cl_r, cl_p_r);
      `ARMC_A_CHI:  rd_mux[7:0] = pick(hob_r, ch_r, ch_p_r);
      `ARMC_A_DEVH: rd_mux[7:0] = dh_r;
      `ARMC_A_CMD:  rd_mux[7:0] = `ARMC_ST_FIXED |
                      ((busy && !drq_r) ? `ARMC_ST_BSY : 8'h00) |
                      (drq_r ? `ARMC_ST_DRQ : 8'h00) |
                      (sterr_r ? `ARMC_ST_ERR : 8'h00);
      `ARMC_A_ERR:  rd_mux[7:0] = err_r;
      `ARMC_A_CTRL: rd_mux[`ARMC_HOB_BIT] = hob_r;
      `ARMC_A_BLK:  rd_mux[7:0] = blk_r;
      default:      rd_mux = 32'h00000000;
    endcase
  end

  // ****************************************
  // Avalon slave handshake
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h00000000;
    end else if (wait_r && (avs_read || avs_write) && rd_ok) begin
      wait_r  <= 1'b0;
      rdata_r <= rd_mux;
    end else begin
      wait_r <= 1'b1;
    end
  end

  a_data_word16: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!avs_waitrequest && avs_read && avs_address == `ARMC_A_DATA)
    |-> avs_readdata[31:16] == 16'h0000)
    else $error("data word wider than 16 bits");

  a_status_fixed: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!avs_waitrequest && avs_read && avs_address == `ARMC_A_CMD)
    |-> (avs_readdata[7:0] & 8'h66) == 8'h40)
    else $error("status fixed bits wrong");

  // ****************************************
  // Command sequencer
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r     <= armc_pkg::ST_IDLE;
      lba_r       <= 48'h000000000000;
      mlba_r      <= 48'h000000000000;
      sect_left_r <= 17'h00000;
      blk_sect_r  <= 8'h00;
      push_cnt_r  <= 8'h00;
      pop_left_r  <= 16'h0000;
      drq_r       <= 1'b0;
      req_r       <= 1'b0;
      cmd48_r     <= 1'b0;
    end else if (fail) begin
      state_r    <= armc_pkg::ST_IDLE;
      drq_r      <= 1'b0;
      req_r      <= 1'b0;
      push_cnt_r <= 8'h00;
    end else begin
      req_r <= 1'b0;
      if (pop) begin
        pop_left_r <= pop_left_r - 16'h0001;
      end
      unique case (state_r)
        armc_pkg::ST_IDLE: if (go) begin
          lba_r       <= start_lba;
          sect_left_r <= start_cnt;
          cmd48_r     <= cmd == `ARMC_CMD_RM48;
          blk_sect_r  <= take_of(start_cnt, blk_r);
          pop_left_r  <= {take_of(start_cnt, blk_r), 8'h00};
          drq_r       <= 1'b1;
          state_r     <= armc_pkg::ST_SEEK;
        end
        armc_pkg::ST_SEEK: begin
          req_r   <= 1'b1;
          mlba_r  <= lba_r;
          state_r <= armc_pkg::ST_STREAM;
        end
        armc_pkg::ST_STREAM: if (push) begin
          push_cnt_r <= push_cnt_r + 8'h01;
          if (push_cnt_r == `ARMC_SECT_LAST) begin
            lba_r       <= lba_r + 48'h000000000001;
            sect_left_r <= sect_left_r - 17'h00001;
            blk_sect_r  <= blk_sect_r - 8'h01;
            if (blk_sect_r == 8'h01) begin
              state_r <= armc_pkg::ST_DRAIN;
            end else begin
              state_r <= armc_pkg::ST_SEEK;
            end
          end
        end
        armc_pkg::ST_DRAIN: if (blk_end) begin
          if (done) begin
            drq_r   <= 1'b0;
            state_r <= armc_pkg::ST_IDLE;
          end else begin
            blk_sect_r <= take_of(sect_left_r, blk_r);
            pop_left_r <= {take_of(sect_left_r, blk_r), 8'h00};
            state_r    <= armc_pkg::ST_SEEK;
          end
        end
      endcase
    end
  end

  a_c4_start: assert property (@(posedge ref_clk) disable iff (!nrst)
    (cmd_wr && cmd == `ARMC_CMD_RM28 && blk_r != 8'h00)
    |=> state_r == armc_pkg::ST_SEEK && !cmd48_r && drq_r)
    else $error("read multiple 28-bit did not start");

  a_29_start: assert property (@(posedge ref_clk) disable iff (!nrst)
    (cmd_wr && cmd == `ARMC_CMD_RM48 && blk_r != 8'h00)
    |=> state_r == armc_pkg::ST_SEEK && cmd48_r)
    else $error("read multiple 48-bit did not start");

  a_seek_req: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_r == armc_pkg::ST_SEEK && !media_err)
    |=> media_req && media_lba == $past(lba_r) ##1 !media_req)
    else $error("media request missing or wrong");

  a_cnt48_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    (go && cmd == `ARMC_CMD_RM48 && {sc_p_r, sc_r} == 16'h0000)
    |=> sect_left_r == `ARMC_CNT48_ZERO)
    else $error("zero count not 65536");

  // ****************************************
  // Interrupt and error reporting
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      intrq_r <= 1'b0;
    end else if (go || abort || fail || (blk_end && !done)) begin
      intrq_r <= 1'b1;
    end else if (acc && avs_read && avs_address == `ARMC_A_CMD) begin
      intrq_r <= 1'b0;
    end
  end

  a_blk_intrq: assert property (@(posedge ref_clk) disable iff (!nrst)
    (blk_end && !done && !fail) |=> host_intrq && drq_r)
    else $error("no interrupt at block start");

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      err_r   <= 8'h00;
      sterr_r <= 1'b0;
    end else if (fail) begin
      err_r   <= media_err_idn ? `ARMC_ER_IDN : `ARMC_ER_UNC;
      sterr_r <= 1'b1;
    end else if (abort) begin
      err_r   <= `ARMC_ER_ABT;
      sterr_r <= 1'b1;
    end else if (go) begin
      err_r   <= 8'h00;
      sterr_r <= 1'b0;
    end
  end

  a_err_clean: assert property (@(posedge ref_clk) disable iff (!nrst)
    (err_r & 8'hab) == 8'h00 && (err_r != 8'h00) == sterr_r)
    else $error("error register reserved bits set");

  a_abort_noblk: assert property (@(posedge ref_clk) disable iff (!nrst)
    (cmd_wr && blk_r == 8'h00)
    |=> err_r == `ARMC_ER_ABT && sterr_r && !drq_r && !busy)
    else $error("command without block size not aborted");

  // ****************************************
  // Taskfile registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      {sc_r, sc_p_r, sn_r, sn_p_r} <= 32'h00000000;
      {cl_r, cl_p_r, ch_r, ch_p_r} <= 32'h00000000;
      dh_r  <= `ARMC_DH_RST;
      hob_r <= 1'b0;
      blk_r <= 8'h00;
    end else begin
      if (fail || done) begin
        sn_r <= wb_lba[7:0];
        cl_r <= wb_lba[15:8];
        ch_r <= wb_lba[23:16];
        if (cmd48_r) begin
          sn_p_r <= wb_lba[31:24];
          cl_p_r <= wb_lba[39:32];
          ch_p_r <= wb_lba[47:40];
        end else begin
          dh_r[3:0] <= wb_lba[27:24];
          sc_r      <= sect_left_r[7:0];
        end
      end else if (tf_wr) begin
        unique case (avs_address)
          `ARMC_A_SCNT: {sc_p_r, sc_r} <= {sc_r, cmd};
          `ARMC_A_SNUM: {sn_p_r, sn_r} <= {sn_r, cmd};
          `ARMC_A_CLO:  {cl_p_r, cl_r} <= {cl_r, cmd};
          `ARMC_A_CHI:  {ch_p_r, ch_r} <= {ch_r, cmd};
          `ARMC_A_DEVH: dh_r <= cmd;
          `ARMC_A_BLK:  blk_r <= cmd;
          default:      blk_r <= blk_r;
        endcase
      end
      if (acc && avs_write && avs_byteenable[0] &&
          avs_address == `ARMC_A_CTRL) begin
        hob_r <= avs_writedata[`ARMC_HOB_BIT];
      end
    end
  end

  a_done_dh: assert property (@(posedge ref_clk) disable iff (!nrst)
    (done && !fail && !cmd48_r)
    |=> {20'h00000, dh_r[3:0], ch_r, cl_r, sn_r} == $past(last_lba))
    else $error("28-bit completion address wrong");

  a_fail_lba: assert property (@(posedge ref_clk) disable iff (!nrst)
    (fail && cmd48_r)
    |=> {ch_p_r, cl_p_r, sn_p_r, ch_r, cl_r, sn_r} == $past(lba_r))
    else $error("failing sector address not kept");

  // ****************************************
  // Data path and outputs
  // ****************************************
  armc_fifo #(
    .W(`ARMC_FIFO_W),
    .D(`ARMC_FIFO_D)
  ) u_fifo (
    .clk       (ref_clk),
    .rst_n     (nrst),
    .flush     (fail),
    .in_data   (media_data),
    .in_valid  (media_valid),
    .in_ready  (fifo_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (pop)
  );

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign host_intrq = intrq_r;
  assign media_req = req_r;
  assign media_lba = mlba_r;
  assign media_ready = fifo_ready;
endmodule
